/* tb/setw_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module setw_mem_model #(
   parameter logic       CS_UPPER = 1'b1,
   parameter logic       CS_LOWER = 1'b0,
   parameter logic [7:0] SN_BASE  = 8'hC3,
   parameter real        BUSY_NS  = 20000.0,
   parameter logic       WP       = 1'b0
) (
   input  wire logic scl,
   input  wire logic sda,
   output var logic  pullLow
);
   logic [7:0] mem [512];
   logic [8:0] ptr = '0;
   logic [7:0] sh, outByte;
   logic       pScl = 1'b1, pSda = 1'b1, ser = 1'b0, wr = 1'b0, pg = 1'b0, snBad = 1'b0;
   int         cnt = 0, ph = 9;
   realtime    busyEnd = 0;
   initial begin
      pullLow = 1'b0;
      for (int i = 0; i < 512; i++) mem[i] = 8'(i) ^ 8'h5A;
   end
   // Phases: 0 device address, 1 word address, 2 write data, 3 read data, 9 idle.
   task automatic ack();
      logic ok;
      ok = 1'b1;
      if (ph == 0) begin
         ok = $realtime >= busyEnd && sh[7:5] == 3'b101
              && sh[3:2] == {CS_UPPER, CS_LOWER};
         ser = sh[4];
         if (!sh[0]) pg = sh[1];
         ph = !ok ? 9 : sh[0] ? 3 : 1;
      end else if (ph == 1) begin
         ptr = ser ? {5'h00, sh[3:0]} : {pg, sh};
         snBad = ser && sh[7:6] != 2'b10;
         ph = 2;
      end else begin
         if (!ser && !WP) mem[ptr] = sh;
         wr = wr | !ser;
         ptr[3:0] = ptr[3:0] + 4'h1;
      end
      pullLow = ok;
   endtask
   always @(scl, sda) begin
      if (scl && pScl && pSda && !sda) begin
         ph = 0;
         cnt = 8;
         pullLow = 1'b0;
      end else if (scl && pScl && !pSda && sda) begin
         if (wr) busyEnd = $realtime + BUSY_NS;
         wr = 1'b0;
         ph = 9;
      end else if (scl && !pScl) begin
         if (cnt < 8) sh = {sh[6:0], sda};
         else if (ph == 3 && sda) ph = 9;
      end else if (!scl && pScl && ph != 9) begin
         cnt = (cnt + 1) % 9;
         pullLow = 1'b0;
         if (cnt == 8 && ph != 3) ack();
         else if (ph == 3) begin
            if (cnt == 0) outByte = !ser ? mem[ptr] : snBad ? 8'h00 : SN_BASE + 8'(ptr[3:0]);
            if (cnt == 0 && ser) ptr[3:0] = ptr[3:0] + 4'h1;
            else if (cnt == 0) ptr = ptr + 9'h001;
            if (cnt < 8) pullLow = !outByte[7 - cnt];
         end
      end
      pScl = scl;
      pSda = sda;
   end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import setw_pkg::*;
   localparam logic [7:0] SN_BASE = 8'hC3;
   logic               core_clk = 1'b0, rst = 1'b1, cmdValid = 1'b0, csUp = 1'b1, csLo = 1'b0;
   setw_op_t           cmdOp = OP_POLL;
   logic [ADDR_W-1:0]  cmdAddr = '0;
   logic [COUNT_W-1:0] cmdCount = '0;
   logic [BYTE_W-1:0]  wrData = '0;
   logic [7:0]         refMem [512];
   logic [7:0]         expQ [$], wq [$];
   logic [15:0]        lf = 16'hE234;
   int                 mismatches = 0, n_tests = 0;
   wire logic          cmdReady, wrTake, rdValid, done, nackErr, scl, sdaOut, sdaOe, pullLow;
   wire logic [7:0]    rdData;
   wire logic          sda = (sdaOe ? sdaOut : 1'b1) & !pullLow;
   always #12.5 core_clk = !core_clk;
   setw_two_wire_host #(.LARGE_VARIANT(1'b0), .QUARTER_LEN(4), .WRITE_TIMEOUT_CYCLES(2000)) dut_u (
      .core_clk(core_clk), .rst(rst), .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdAddr(cmdAddr),
      .cmdCount(cmdCount), .wrData(wrData), .chipSelectPinUpper(csUp),
      .chipSelectPinLower(csLo), .cmdReady(cmdReady), .wrTake(wrTake), .rdData(rdData),
      .rdValid(rdValid), .done(done), .nackErr(nackErr), .scl(scl), .sdaIn(sda),
      .sdaOut(sdaOut), .sdaOe(sdaOe));
   setw_mem_model #(.SN_BASE(SN_BASE)) mem_u (.scl(scl), .sda(sda), .pullLow(pullLow));
   function automatic logic [15:0] lfsrNext(logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic results();
      $display("mismatches %0d n_tests %0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Runs one command and checks every read byte against the queue built from the reference.
   task automatic run(setw_op_t op, int addr, int cnt, logic expNack);
      int t;
      while (cmdReady !== 1'b1) @(negedge core_clk);
      cmdOp = op;
      cmdAddr = 10'(addr);
      cmdCount = 8'(cnt);
      cmdValid = 1'b1;
      if (wq.size() > 0) wrData = wq[0];
      @(negedge core_clk);
      cmdValid = 1'b0;
      t = 0;
      while (done !== 1'b1 && t < 20000) begin
         if (wrTake === 1'b1) void'(wq.pop_front());
         if (wrTake === 1'b1 && wq.size() > 0) wrData = wq[0];
         if (rdValid === 1'b1) chk("rdData", rdData, expQ.pop_front());
         @(negedge core_clk);
         t++;
      end
      chk("done", 8'(done), 8'h01);
      chk("cmdReady", 8'(cmdReady), 8'h01);
      chk("scl", 8'(scl), 8'h01);
      chk("sdaOut", 8'(sdaOut), 8'h00);
      chk("sdaOe", 8'(sdaOe), 8'h00);
      chk("nackErr", 8'(nackErr), 8'(expNack));
      chk("readCount", 8'(expQ.size()), 8'h00);
      chk("wrLeft", 8'(wq.size()), 8'h00);
   endtask
   initial begin
      for (int i = 0; i < 512; i++) refMem[i] = 8'(i) ^ 8'h5A;
      repeat (2) @(negedge core_clk);
      rst = 1'b0;
      run(OP_RECOVER, 0, 0, 1'b0);
      run(OP_POLL, 0, 0, 1'b0);
      for (int i = 0; i < 16; i++) begin
         lf = lfsrNext(lf);
         wq.push_back(lf[7:0]);
         refMem[9'h1F0 + 9'((8 + i) % 16)] = lf[7:0];
      end
      run(OP_WRITE, 'h1F8, 17, 1'b0);
      for (int i = 0; i < 16; i++) expQ.push_back(refMem[9'h1F0 + 9'(i)]);
      run(OP_READ_RAND, 'h1F0, 15, 1'b0);
      for (int i = 0; i < 2; i++) expQ.push_back(refMem[i]);
      run(OP_READ_CUR, 0, 1, 1'b0);
      for (int i = 0; i < 18; i++) expQ.push_back(SN_BASE + 8'((3 + i) % 16));
      run(OP_READ_SERIAL, 3, 17, 1'b0);
      csUp = 1'b0;
      run(OP_READ_RAND, 5, 0, 1'b1);
      csUp = 1'b1;
      csLo = 1'b1;
      run(OP_READ_CUR, 0, 0, 1'b1);
      results();
   end
   initial begin
      #2_000_000;
      mismatches++;
      results();
   end
endmodule
`default_nettype wire

/* verilog/setw_pkg.sv */
`default_nettype none
package setw_pkg;

   // Core clock and the bus rate that the divider aims at.
   localparam int CORE_CLK_HZ      = 40_000_000;
   localparam int SCL_RATE_HZ      = 400_000;
   localparam int QUARTERS_PER_BIT = 4;
   // A bit period may not be shorter than the fastest allowed rate, so round up.
   localparam int QUARTER_CYCLES   = (CORE_CLK_HZ + QUARTERS_PER_BIT * SCL_RATE_HZ - 1)
                                     / (QUARTERS_PER_BIT * SCL_RATE_HZ);

   // Self-timed write in the memory; polling gives up after this long.
   localparam int INTERNAL_WRITE_TIME_MS = 5;
   localparam int INTERNAL_WRITE_CYCLES  = INTERNAL_WRITE_TIME_MS * (CORE_CLK_HZ / 1000);

   localparam int ADDR_W  = 10;
   localparam int BYTE_W  = 8;
   localparam int COUNT_W = 8;

   localparam logic [3:0] ARRAY_PATTERN      = 4'hA;
   localparam logic [3:0] SERIAL_PATTERN     = 4'hB;
   localparam logic [1:0] SERIAL_WORD_PREFIX = 2'h2;
   localparam logic [1:0] PAGE_BITS_SERIAL   = 2'h0;
   localparam logic [3:0] PAGE_EXTRA_MAX     = 4'hF;
   localparam logic [4:0] PAGE_BYTES         = 5'h10;

   // Nine slots per byte: eight data bits and the acknowledge; recovery also clocks nine.
   localparam logic [3:0] BIT_LAST       = 4'h8;
   localparam logic [8:0] SHIFT_RELEASED = 9'h1FF;
   localparam logic [7:0] RX_RELEASED    = 8'hFF;

   // Quarters of one bit slot.
   localparam logic [1:0] Q_LOW_A  = 2'h0;
   localparam logic [1:0] Q_HIGH_A = 2'h1;
   localparam logic [1:0] Q_HIGH_B = 2'h2;
   localparam logic [1:0] Q_LOW_B  = 2'h3;

   typedef enum logic [2:0] {
      OP_WRITE,
      OP_READ_CUR,
      OP_READ_RAND,
      OP_READ_SERIAL,
      OP_POLL,
      OP_RECOVER
   } setw_op_t;

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_START,
      ST_DEVADDR,
      ST_WORDADDR,
      ST_WRDATA,
      ST_RDADDR,
      ST_RDDATA,
      ST_RECOVER,
      ST_STOP
   } setw_state_t;

endpackage
`default_nettype wire

/* verilog/setw_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module setw_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             core_clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);

   logic [WIDTH-1:0] stage1_r;
   logic [WIDTH-1:0] stage2_r;

   // The first stage may be metastable, so only the second stage reads it.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         stage1_r <= {WIDTH{1'b1}};
         stage2_r <= {WIDTH{1'b1}};
      end else begin
         stage1_r <= asyncIn;
         stage2_r <= stage1_r;
      end
   end

   assign syncOut = stage2_r;

endmodule
`default_nettype wire

/* verilog/setw_two_wire_host.sv */
`timescale 1ns/1ps
`default_nettype none
module setw_two_wire_host
   import setw_pkg::*;
#(
   parameter bit LARGE_VARIANT        = 1'b0,
   parameter int QUARTER_LEN          = setw_pkg::QUARTER_CYCLES,
   parameter int WRITE_TIMEOUT_CYCLES = setw_pkg::INTERNAL_WRITE_CYCLES
) (
   input  wire logic                           core_clk,
   input  wire logic                           rst,
   input  wire logic                           cmdValid,
   input  wire setw_pkg::setw_op_t             cmdOp,
   input  wire logic [setw_pkg::ADDR_W-1:0]    cmdAddr,
   input  wire logic [setw_pkg::COUNT_W-1:0]   cmdCount,
   input  wire logic [setw_pkg::BYTE_W-1:0]    wrData,
   input  wire logic                           chipSelectPinUpper,
   input  wire logic                           chipSelectPinLower,
   output logic                                cmdReady,
   output logic                                wrTake,
   output logic [setw_pkg::BYTE_W-1:0]         rdData,
   output logic                                rdValid,
   output logic                                done,
   output logic                                nackErr,
   output logic                                scl,
   input  wire logic                           sdaIn,
   output logic                                sdaOut,
   output logic                                sdaOe
);

   import setw_pkg::*;

   localparam int DIV_W   = $clog2(QUARTER_LEN + 1);
   localparam int TIMER_W = $clog2(WRITE_TIMEOUT_CYCLES + 1);
   localparam logic [DIV_W-1:0]   QUARTER_LAST = DIV_W'(QUARTER_LEN - 1);
   localparam logic [TIMER_W-1:0] TIMER_LAST   = TIMER_W'(WRITE_TIMEOUT_CYCLES - 1);

   setw_state_t            state_r;
   setw_state_t            stateNxt;
   setw_op_t               op_r;
   setw_op_t               opNxt;
   logic [ADDR_W-1:0]      addr_r;
   logic [COUNT_W-1:0]     remain_r;
   logic [COUNT_W-1:0]     remainNxt;
   logic [8:0]             shift_r;
   logic [8:0]             shiftNxt;
   logic [8:0]             rx_r;
   logic [3:0]             bitIdx_r;
   logic [1:0]             quarter_r;
   logic [DIV_W-1:0]       divCnt_r;
   logic [TIMER_W-1:0]     timer_r;
   logic                   again_r;
   logic                   againNxt;
   logic                   acked_r;
   logic                   ackedNxt;
   logic                   sclOut_r;
   logic                   sdaOe_r;
   logic                   sdaOut_r;
   logic                   slotIsBit_r;
   logic                   cmdReady_r;
   logic                   wrTake_r;
   logic [BYTE_W-1:0]      rdData_r;
   logic                   rdValid_r;
   logic                   done_r;
   logic                   nackErr_r;
   logic                   cmdTake;
   logic                   errSet;
   logic                   doneSet;
   logic                   takeSet;
   logic                   rdSet;
   logic                   timerClr;
   logic                   sdaSync;
   logic [1:0]             csSync;

   setw_sync #(
      .WIDTH(1)
   ) u_sdaSync (
      .core_clk(core_clk),
      .rst     (rst),
      .asyncIn (sdaIn),
      .syncOut (sdaSync)
   );

   // The select straps are pins too, so they pass the same two stages.
   setw_sync #(
      .WIDTH(2)
   ) u_csSync (
      .core_clk(core_clk),
      .rst     (rst),
      .asyncIn ({chipSelectPinUpper, chipSelectPinLower}),
      .syncOut (csSync)
   );

   // Page bits sit above the received word address byte.
   function automatic logic [7:0] devAddrByte(input logic serial,
                                              input logic rd,
                                              input logic [ADDR_W-1:0] a,
                                              input logic csUpper,
                                              input logic csLower);
      logic [7:0] b;
      b      = 8'h00;
      b[7:4] = serial ? SERIAL_PATTERN : ARRAY_PATTERN;
      b[3]   = csUpper;
      if (LARGE_VARIANT) begin
         b[2:1] = serial ? PAGE_BITS_SERIAL : a[9:8];
      end else begin
         b[2] = csLower;
         b[1] = serial ? 1'b0 : a[8];
      end
      b[0] = rd;
      return b;
   endfunction

   wire isIdle      = (state_r == ST_IDLE);
   wire isStart     = (state_r == ST_START);
   wire isStop      = (state_r == ST_STOP);
   wire isByte      = !(isIdle || isStart || isStop);
   wire isSerial    = (op_r == OP_READ_SERIAL);
   wire tick        = !isIdle && (divCnt_r == QUARTER_LAST);
   wire slotEnd     = tick && (quarter_r == Q_LOW_B);
   wire byteEnd     = slotEnd && isByte && (bitIdx_r == BIT_LAST);
   wire sampleNow   = tick && (quarter_r == Q_HIGH_B);
   wire nack        = rx_r[0];
   wire timeout     = (timer_r == TIMER_LAST);
   wire lastByte    = (remain_r == '0);
   wire [7:0] wrDev = devAddrByte(isSerial, 1'b0, addr_r, csSync[1], csSync[0]);
   wire [7:0] rdDev = devAddrByte(isSerial, 1'b1, addr_r, csSync[1], csSync[0]);
   // Serial reads force the top two word address bits.
   wire [7:0] wordByte = isSerial ? {SERIAL_WORD_PREFIX, 2'h0, addr_r[3:0]}
                                  : addr_r[7:0];
   // A page holds sixteen bytes; more would overwrite the first ones.
   wire pageClamp = (cmdOp == OP_WRITE) && (cmdCount > COUNT_W'(PAGE_EXTRA_MAX));
   wire [COUNT_W-1:0] startCount = pageClamp ? COUNT_W'(PAGE_EXTRA_MAX) : cmdCount;

   // Bus levels for each quarter: the clock is high in the middle two quarters.
   wire sclWant = isIdle || (quarter_r == Q_HIGH_A) || (quarter_r == Q_HIGH_B)
                  || (isStop && (quarter_r == Q_LOW_B));
   wire sdaRelStart = (quarter_r == Q_LOW_A) || (quarter_r == Q_HIGH_A);
   wire sdaRelStop  = (quarter_r == Q_HIGH_B) || (quarter_r == Q_LOW_B);
   wire sdaRelWant  = isIdle ? 1'b1 : isStart ? sdaRelStart : isStop ? sdaRelStop
                      : shift_r[8];

   always_comb begin
      stateNxt  = state_r;
      opNxt     = op_r;
      remainNxt = remain_r;
      shiftNxt  = shift_r;
      againNxt  = again_r;
      ackedNxt  = acked_r;
      cmdTake   = 1'b0;
      errSet    = 1'b0;
      doneSet   = 1'b0;
      takeSet   = 1'b0;
      rdSet     = 1'b0;
      timerClr  = 1'b0;
      if (slotEnd && isByte) begin
         shiftNxt = {shift_r[7:0], 1'b1};
      end
      case (state_r)
         ST_IDLE: begin
            if (cmdValid) begin
               cmdTake   = 1'b1;
               stateNxt  = ST_START;
               opNxt     = cmdOp;
               remainNxt = startCount;
               againNxt  = 1'b0;
               ackedNxt  = 1'b0;
               timerClr  = 1'b1;
            end
         end
         ST_START: begin
            if (slotEnd) begin
               if (op_r == OP_RECOVER) begin
                  if (again_r) begin
                     stateNxt = ST_STOP;
                  end else begin
                     stateNxt = ST_RECOVER;
                     shiftNxt = SHIFT_RELEASED;
                  end
               end else if (again_r || (op_r == OP_READ_CUR)) begin
                  // The pointer is left where the last access put it.
                  stateNxt = ST_RDADDR;
                  shiftNxt = {rdDev, 1'b1};
               end else begin
                  stateNxt = ST_DEVADDR;
                  shiftNxt = {wrDev, 1'b1};
               end
            end
         end
         ST_RECOVER: begin
            if (byteEnd) begin
               stateNxt = ST_START;
               againNxt = 1'b1;
            end
         end
         ST_DEVADDR: begin
            if (byteEnd) begin
               if (nack) begin
                  stateNxt = ST_STOP;
                  errSet   = (op_r != OP_POLL);
               end else if (op_r == OP_POLL) begin
                  stateNxt = ST_STOP;
                  ackedNxt = 1'b1;
               end else begin
                  stateNxt = ST_WORDADDR;
                  shiftNxt = {wordByte, 1'b1};
               end
            end
         end
         ST_WORDADDR: begin
            if (byteEnd) begin
               if (nack) begin
                  stateNxt = ST_STOP;
                  errSet   = 1'b1;
               end else if (op_r == OP_WRITE) begin
                  stateNxt = ST_WRDATA;
                  shiftNxt = {wrData, 1'b1};
                  takeSet  = 1'b1;
               end else begin
                  stateNxt = ST_START;
                  againNxt = 1'b1;
               end
            end
         end
         ST_WRDATA: begin
            if (byteEnd) begin
               if (nack) begin
                  stateNxt = ST_STOP;
                  errSet   = 1'b1;
               end else if (lastByte) begin
                  stateNxt = ST_STOP;
               end else begin
                  remainNxt = remain_r - 1'b1;
                  shiftNxt  = {wrData, 1'b1};
                  takeSet   = 1'b1;
               end
            end
         end
         ST_RDADDR: begin
            if (byteEnd) begin
               if (nack) begin
                  stateNxt = ST_STOP;
                  errSet   = 1'b1;
               end else begin
                  stateNxt = ST_RDDATA;
                  shiftNxt = {RX_RELEASED, lastByte};
               end
            end
         end
         ST_RDDATA: begin
            if (byteEnd) begin
               rdSet = 1'b1;
               if (lastByte) begin
                  stateNxt = ST_STOP;
               end else begin
                  remainNxt = remain_r - 1'b1;
                  shiftNxt  = {RX_RELEASED, (remain_r == COUNT_W'(1))};
               end
            end
         end
         ST_STOP: begin
            if (slotEnd) begin
               if ((op_r == OP_WRITE) && !nackErr_r) begin
                  // The Stop starts the self-timed write; poll until it answers.
                  opNxt    = OP_POLL;
                  againNxt = 1'b0;
                  timerClr = 1'b1;
                  stateNxt = ST_START;
               end else if ((op_r == OP_POLL) && !acked_r && !timeout) begin
                  stateNxt = ST_START;
               end else begin
                  stateNxt = ST_IDLE;
                  doneSet  = 1'b1;
                  errSet   = (op_r == OP_POLL) && !acked_r;
               end
            end
         end
         default: begin
            stateNxt = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_r  <= ST_IDLE;
         op_r     <= OP_WRITE;
         remain_r <= '0;
         shift_r  <= SHIFT_RELEASED;
         again_r  <= 1'b0;
         acked_r  <= 1'b0;
      end else begin
         state_r  <= stateNxt;
         op_r     <= opNxt;
         remain_r <= remainNxt;
         shift_r  <= shiftNxt;
         again_r  <= againNxt;
         acked_r  <= ackedNxt;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         addr_r <= '0;
      end else if (cmdTake) begin
         addr_r <= cmdAddr;
      end
   end

   // Divider and slot position; idle holds them at zero so each command starts clean.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         divCnt_r  <= '0;
         quarter_r <= Q_LOW_A;
         bitIdx_r  <= '0;
      end else begin
         divCnt_r  <= (isIdle || tick) ? '0 : divCnt_r + 1'b1;
         quarter_r <= isIdle ? Q_LOW_A : tick ? quarter_r + 1'b1 : quarter_r;
         bitIdx_r  <= (isIdle || byteEnd || !isByte) ? '0
                      : slotEnd ? bitIdx_r + 1'b1 : bitIdx_r;
      end
   end

   // The sample is taken at the end of the clock-high time, on the last cycle of the second high quarter.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rx_r <= SHIFT_RELEASED;
      end else if (sampleNow) begin
         rx_r <= {rx_r[7:0], sdaSync};
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         timer_r <= '0;
      end else begin
         timer_r <= timerClr ? '0 : (timeout ? timer_r : timer_r + 1'b1);
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sclOut_r    <= 1'b1;
         sdaOe_r     <= 1'b0;
         sdaOut_r    <= 1'b0;
         slotIsBit_r <= 1'b0;
         cmdReady_r  <= 1'b0;
         wrTake_r    <= 1'b0;
         rdData_r    <= '0;
         rdValid_r   <= 1'b0;
         done_r      <= 1'b0;
         nackErr_r   <= 1'b0;
      end else begin
         sclOut_r    <= sclWant;
         sdaOe_r     <= !sdaRelWant;
         sdaOut_r    <= 1'b0;
         slotIsBit_r <= isByte;
         cmdReady_r  <= (stateNxt == ST_IDLE);
         wrTake_r    <= takeSet;
         rdData_r    <= rdSet ? rx_r[8:1] : rdData_r;
         rdValid_r   <= rdSet;
         done_r      <= doneSet;
         nackErr_r   <= errSet | (nackErr_r & !cmdTake);
      end
   end

   assign cmdReady = cmdReady_r;
   assign wrTake   = wrTake_r;
   assign rdData   = rdData_r;
   assign rdValid  = rdValid_r;
   assign done     = done_r;
   assign nackErr  = nackErr_r;
   assign scl      = sclOut_r;
   assign sdaOut   = sdaOut_r;
   assign sdaOe    = sdaOe_r;

   logic [4:0] takeCnt_r;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         takeCnt_r <= '0;
      end else begin
         takeCnt_r <= cmdTake ? '0 : takeCnt_r + {4'h0, wrTake_r};
      end
   end

   wire [3:0] patNow = isSerial ? SERIAL_PATTERN : ARRAY_PATTERN;
   wire       inAddr = (state_r == ST_DEVADDR) || (state_r == ST_RDADDR);
   wire       txByte = inAddr || (state_r == ST_WORDADDR) || (state_r == ST_WRDATA);

   sda_stable_a: assert property (@(posedge core_clk) disable iff (rst)
      sclOut_r && $past(sclOut_r) && slotIsBit_r && $past(slotIsBit_r) |-> $stable(sdaOe_r))
      else $error("data line moved while clock high in a bit slot");
   start_first_a: assert property (@(posedge core_clk) disable iff (rst)
      $rose(state_r == ST_DEVADDR) |-> $past(state_r) == ST_START)
      else $error("address word sent without a start");
   stop_idle_a: assert property (@(posedge core_clk) disable iff (rst)
      done_r |-> $past(state_r == ST_STOP) && sclOut_r && !sdaOe_r)
      else $error("command ended without a stop on an idle bus");
   ack_release_a: assert property (@(posedge core_clk) disable iff (rst)
      sclOut_r && txByte && bitIdx_r == BIT_LAST |-> !sdaOe_r)
      else $error("host drove data during the memory acknowledge");
   addr_pattern_a: assert property (@(posedge core_clk) disable iff (rst)
      sclOut_r && inAddr && bitIdx_r < 4'h4 |-> sdaOe_r == !patNow[3 - bitIdx_r[1:0]])
      else $error("address word pattern bits wrong");
   rw_bit_a: assert property (@(posedge core_clk) disable iff (rst)
      sclOut_r && inAddr && bitIdx_r == 4'h7 |-> sdaOe_r == (state_r == ST_DEVADDR))
      else $error("direction bit wrong");
   serial_word_a: assert property (@(posedge core_clk) disable iff (rst)
      sclOut_r && isSerial && state_r == ST_WORDADDR && bitIdx_r < 4'h2
      |-> sdaOe_r == bitIdx_r[0])
      else $error("serial word address does not start with 10");
   read_ack_a: assert property (@(posedge core_clk) disable iff (rst)
      sclOut_r && state_r == ST_RDDATA && bitIdx_r == BIT_LAST |-> sdaOe_r == !lastByte)
      else $error("read acknowledge does not match remaining bytes");
   page_limit_a: assert property (@(posedge core_clk) disable iff (rst)
      takeCnt_r <= PAGE_BYTES)
      else $error("more than one page of data sent in one write");
   recover_free_a: assert property (@(posedge core_clk) disable iff (rst)
      sclOut_r && state_r == ST_RECOVER |-> !sdaOe_r)
      else $error("data line driven during recovery clocks");
   poll_stop_a: assert property (@(posedge core_clk) disable iff (rst)
      $rose(acked_r) |-> state_r == ST_STOP ##1 state_r == ST_STOP)
      else $error("acknowledged poll not followed by stop");

   write_done_c: cover property (@(posedge core_clk) disable iff (rst)
      done_r && !nackErr_r && op_r == OP_POLL);
   read_byte_c: cover property (@(posedge core_clk) disable iff (rst)
      rdValid_r && op_r == OP_READ_RAND);
   serial_read_c: cover property (@(posedge core_clk) disable iff (rst)
      rdValid_r && isSerial);
   recover_done_c: cover property (@(posedge core_clk) disable iff (rst)
      done_r && op_r == OP_RECOVER);

endmodule
`default_nettype wire
